// ===== rtl/uepcs_pkg.sv
// constants and types for the endpoint configuration and status block
// Function
// - reserve bit claims memory; bus reset spares endpoint 0
// - bank count codes 1..3 banks, 11 reserved
// - bank size 8 to 1024 bytes, doubling
// - direction 0 OUT, 1 IN; bus reset clears
// - auto switch advances banks; bus reset clears
// - kind: control, iso, bulk, interrupt encoding
// - control IN ready; clearing it sends packet
// - non-control IN ready with handover on free bank
// - control OUT received; clearing frees bank
// - non-control OUT received with handover on full bank
// - shared bit: setup, iso underrun, else zero
// - iso IN empty bank: underrun, zero length packet
// - iso OUT full bank: drop packet, underrun
// - NAK to OUT sets OUT refused flag
// - NAK to IN sets IN refused flag
// - oversize OUT: acknowledge, received flag, oversize flag
// - stall request answers STALL, sets stall sent
// - config valid re-evaluated on reserve, checks fit
// - toggle state resets to 01
// - status clear write-one clears, reads zero
package uepcs_pkg;
  localparam int unsigned NUM_EP = 7;
  // register bases, one word per endpoint
  localparam logic [8:0] CFG_BASE = 9'h100;
  localparam logic [8:0] STA_BASE = 9'h130;
  localparam logic [8:0] CLR_BASE = 9'h160;
  localparam logic [8:0] CON_BASE = 9'h1c0;
  localparam logic [8:0] EP_SPAN = 9'h01c;
  // configuration fields
  localparam int unsigned CFG_RESERVE = 1;
  localparam int unsigned CFG_BANKS = 2;
  localparam int unsigned CFG_SIZE = 4;
  localparam int unsigned CFG_DIR = 8;
  localparam int unsigned CFG_AUTO = 9;
  localparam int unsigned CFG_KIND = 11;
  // status fields
  localparam int unsigned ST_IN_READY = 0;
  localparam int unsigned ST_OUT_RECV = 1;
  localparam int unsigned ST_SETUP = 2;
  localparam int unsigned ST_OUT_REF = 3;
  localparam int unsigned ST_IN_REF = 4;
  localparam int unsigned ST_OVERS = 5;
  localparam int unsigned ST_STALL = 6;
  localparam int unsigned ST_TOGGLE = 8;
  localparam int unsigned ST_NBUSY = 12;
  localparam int unsigned ST_CURR = 14;
  localparam int unsigned ST_CONFIG_VALID = 18;
  // control word fields
  localparam int unsigned CON_STALL_SET = 0;
  localparam int unsigned CON_STALL_CLR = 1;
  localparam int unsigned CON_HAND_CLR = 2;
  localparam int unsigned CON_HANDOVER = 3;
  localparam int unsigned CON_IRQEN = 8;
  // reset values and limits
  localparam logic [1:0] TOGGLE_RST = 2'h1;
  localparam logic [31:0] STATUS_RST = 32'h00000100;
  localparam logic [1:0] BANKS_RSVD = 2'h3;
  localparam logic [1:0] EP0_MAX_BANKS = 2'h0;
  localparam logic [1:0] EPN_MAX_BANKS = 2'h2;
  localparam logic [15:0] MEM_BYTES = 16'h1000;
  // endpoint kinds
  localparam logic [1:0] KIND_CTRL = 2'h0;
  localparam logic [1:0] KIND_ISO = 2'h1;
  localparam logic [1:0] KIND_BULK = 2'h2;
  localparam logic [1:0] KIND_INTR = 2'h3;
  // token kinds from the link
  localparam logic [1:0] TOK_IN = 2'h0;
  localparam logic [1:0] TOK_OUT = 2'h1;
  localparam logic [1:0] TOK_SETUP = 2'h2;
  typedef enum logic [2:0] {
    HS_NONE, HS_ACK, HS_NAK, HS_STALL, HS_DATA, HS_ZLP, HS_DROP
  } uepcs_hs_type;
endpackage

// ===== rtl/uepcs_endpoint_ctrl.sv
// per-endpoint configuration, bank handover and status flags
`timescale 1ns/1ps
module uepcs_endpoint_ctrl (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  // register port
  input wire logic [8:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // link side transactions
  input wire logic usb_reset_i,
  input wire logic tok_valid_i,
  input wire logic [2:0] tok_ep_i,
  input wire logic [1:0] tok_kind_i,
  input wire logic tok_oversize_i,
  // handshake answer
  output logic hs_valid_o,
  output uepcs_pkg::uepcs_hs_type hs_code_o,
  output logic [2:0] hs_ep_o,
  // interrupt lines
  output logic [6:0] endpoint_irq_o
);
  localparam int unsigned N = uepcs_pkg::NUM_EP;

  // address decode helpers
  function automatic logic hit(input logic [8:0] a, input logic [8:0] b);
    logic [8:0] d;
    d = a - b;
    hit = (a >= b) && (d < uepcs_pkg::EP_SPAN) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [2:0] idx(input logic [8:0] a,
                                     input logic [8:0] b);
    logic [8:0] d;
    d = a - b;
    idx = d[4:2];
  endfunction

  // banks in use; without auto switch only one bank cycles
  function automatic logic [1:0] eff_banks(input logic [1:0] bk,
                                           input logic au);
    if (!au) begin
      eff_banks = 2'h1;
    end else if (bk == uepcs_pkg::BANKS_RSVD) begin
      eff_banks = 2'h3;
    end else begin
      eff_banks = bk + 2'h1;
    end
  endfunction

  // buffer bytes claimed by one endpoint
  function automatic logic [15:0] bytes(input logic [1:0] bk,
                                        input logic [2:0] sz);
    bytes = ({14'h0, bk} + 16'h1) << ({1'b0, sz} + 4'h3);
  endfunction

  // configuration state
  logic [N-1:0] reserve_ff, dir_ff, auto_ff, config_valid_ff, stall_ff;
  logic [1:0] banks_ff [N];
  logic [2:0] size_ff [N];
  logic [1:0] kind_ff [N];
  logic [7:0] irqen_ff [N];
  // bank and flag state
  logic [N-1:0] handover_ff, loaded_ff;
  logic [1:0] nbusy_ff [N];
  logic [1:0] curr_ff [N];
  logic [1:0] toggle_ff [N];
  logic [7:0] flag_ff [N];
  // output registers
  logic [31:0] rdata_ff;
  logic hs_valid_ff;
  uepcs_pkg::uepcs_hs_type hs_code_ff;
  logic [2:0] hs_ep_ff;
  logic [6:0] irq_ff;

  // decoded bus access
  logic cfg_wr, clr_wr, con_wr;
  logic [2:0] cfg_ix, clr_ix, con_ix;
  logic [15:0] mem_used;
  logic cfg_fits;
  logic [1:0] new_banks;
  logic [2:0] new_size;

  always_comb begin
    cfg_wr = wr_i && hit(addr_i, uepcs_pkg::CFG_BASE);
    clr_wr = wr_i && hit(addr_i, uepcs_pkg::CLR_BASE);
    con_wr = wr_i && hit(addr_i, uepcs_pkg::CON_BASE);
    cfg_ix = idx(addr_i, uepcs_pkg::CFG_BASE);
    clr_ix = idx(addr_i, uepcs_pkg::CLR_BASE);
    con_ix = idx(addr_i, uepcs_pkg::CON_BASE);
  end

  // memory check: other reserved endpoints plus the new request
  always_comb begin
    new_banks = wdata_i[uepcs_pkg::CFG_BANKS +: 2];
    new_size = wdata_i[uepcs_pkg::CFG_SIZE +: 3];
    mem_used = bytes(new_banks, new_size);
    for (int e = 0; e < N; e++) begin
      if (reserve_ff[e] && (3'(e) != cfg_ix)) begin
        mem_used = mem_used + bytes(banks_ff[e], size_ff[e]);
      end
    end
    cfg_fits = (new_banks != uepcs_pkg::BANKS_RSVD) &&
               (mem_used <= uepcs_pkg::MEM_BYTES) &&
               (new_banks <= ((cfg_ix == 3'h0) ? uepcs_pkg::EP0_MAX_BANKS
                                               : uepcs_pkg::EPN_MAX_BANKS));
  end

  // configuration words; bus reset spares endpoint 0 allocation
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reserve_ff <= '0;
      dir_ff <= '0;
      auto_ff <= '0;
      config_valid_ff <= '0;
      for (int e = 0; e < N; e++) begin
        banks_ff[e] <= 2'h0;
        size_ff[e] <= 3'h0;
        kind_ff[e] <= 2'h0;
      end
    end else if (en_i) begin
      if (usb_reset_i) begin
        for (int e = 1; e < N; e++) begin
          reserve_ff[e] <= 1'b0;
          banks_ff[e] <= 2'h0;
          size_ff[e] <= 3'h0;
        end
        dir_ff <= '0;
        auto_ff <= '0;
        for (int e = 0; e < N; e++) begin
          kind_ff[e] <= 2'h0;
        end
      end else if (cfg_wr) begin
        reserve_ff[cfg_ix] <= wdata_i[uepcs_pkg::CFG_RESERVE];
        banks_ff[cfg_ix] <= new_banks;
        size_ff[cfg_ix] <= new_size;
        dir_ff[cfg_ix] <= wdata_i[uepcs_pkg::CFG_DIR];
        auto_ff[cfg_ix] <= wdata_i[uepcs_pkg::CFG_AUTO];
        kind_ff[cfg_ix] <= wdata_i[uepcs_pkg::CFG_KIND +: 2];
        if (wdata_i[uepcs_pkg::CFG_RESERVE]) begin
          config_valid_ff[cfg_ix] <= cfg_fits;
        end
      end
    end
  end

  // link transaction decisions and per-endpoint events
  uepcs_pkg::uepcs_hs_type nxt_hs;
  logic [N-1:0] ev_fill, ev_take, ev_sent, ev_setup, ev_data;
  logic [N-1:0] grant, release_bank, ctl_free, launch;
  logic [7:0] set_vec [N];
  logic [7:0] clr_vec [N];

  always_comb begin
    nxt_hs = uepcs_pkg::HS_NONE;
    ev_fill = '0;
    ev_take = '0;
    ev_sent = '0;
    ev_setup = '0;
    ev_data = '0;
    for (int e = 0; e < N; e++) begin
      set_vec[e] = 8'h00;
    end
    if (tok_valid_i && (tok_ep_i < 3'(N)) && reserve_ff[tok_ep_i]) begin
      if (tok_kind_i == uepcs_pkg::TOK_SETUP) begin
        if (kind_ff[tok_ep_i] == uepcs_pkg::KIND_CTRL) begin
          nxt_hs = uepcs_pkg::HS_ACK;
          ev_fill[tok_ep_i] = 1'b1;
          ev_setup[tok_ep_i] = 1'b1;
          set_vec[tok_ep_i][uepcs_pkg::ST_SETUP] = 1'b1;
        end
      end else if (stall_ff[tok_ep_i]) begin
        nxt_hs = uepcs_pkg::HS_STALL;
        set_vec[tok_ep_i][uepcs_pkg::ST_STALL] = 1'b1;
      end else if (tok_kind_i == uepcs_pkg::TOK_IN) begin
        if (kind_ff[tok_ep_i] == uepcs_pkg::KIND_CTRL) begin
          if (loaded_ff[tok_ep_i]) begin
            nxt_hs = uepcs_pkg::HS_DATA;
            ev_sent[tok_ep_i] = 1'b1;
            ev_data[tok_ep_i] = 1'b1;
          end else begin
            nxt_hs = uepcs_pkg::HS_NAK;
            set_vec[tok_ep_i][uepcs_pkg::ST_IN_REF] = 1'b1;
          end
        end else if (dir_ff[tok_ep_i]) begin
          if (nbusy_ff[tok_ep_i] != 2'h0) begin
            nxt_hs = uepcs_pkg::HS_DATA;
            ev_take[tok_ep_i] = 1'b1;
            ev_data[tok_ep_i] = 1'b1;
          end else if (kind_ff[tok_ep_i] == uepcs_pkg::KIND_ISO) begin
            nxt_hs = uepcs_pkg::HS_ZLP;
            set_vec[tok_ep_i][uepcs_pkg::ST_SETUP] = 1'b1;
          end else begin
            nxt_hs = uepcs_pkg::HS_NAK;
            set_vec[tok_ep_i][uepcs_pkg::ST_IN_REF] = 1'b1;
          end
        end
      end else if (tok_kind_i == uepcs_pkg::TOK_OUT) begin
        if (kind_ff[tok_ep_i] == uepcs_pkg::KIND_CTRL) begin
          if ((nbusy_ff[tok_ep_i] == 2'h0) && !loaded_ff[tok_ep_i]) begin
            nxt_hs = uepcs_pkg::HS_ACK;
            ev_fill[tok_ep_i] = 1'b1;
            ev_data[tok_ep_i] = 1'b1;
            set_vec[tok_ep_i][uepcs_pkg::ST_OUT_RECV] = 1'b1;
            set_vec[tok_ep_i][uepcs_pkg::ST_OVERS] = tok_oversize_i;
          end else begin
            nxt_hs = uepcs_pkg::HS_NAK;
            set_vec[tok_ep_i][uepcs_pkg::ST_OUT_REF] = 1'b1;
          end
        end else if (!dir_ff[tok_ep_i]) begin
          if (nbusy_ff[tok_ep_i] <
              eff_banks(banks_ff[tok_ep_i], auto_ff[tok_ep_i])) begin
            nxt_hs = uepcs_pkg::HS_ACK;
            ev_fill[tok_ep_i] = 1'b1;
            ev_data[tok_ep_i] = 1'b1;
            set_vec[tok_ep_i][uepcs_pkg::ST_OVERS] = tok_oversize_i;
          end else if (kind_ff[tok_ep_i] == uepcs_pkg::KIND_ISO) begin
            nxt_hs = uepcs_pkg::HS_DROP;
            set_vec[tok_ep_i][uepcs_pkg::ST_SETUP] = 1'b1;
          end else begin
            nxt_hs = uepcs_pkg::HS_NAK;
            set_vec[tok_ep_i][uepcs_pkg::ST_OUT_REF] = 1'b1;
          end
        end
      end
    end
    // bank grants and software side events
    for (int e = 0; e < N; e++) begin
      clr_vec[e] = (clr_wr && (clr_ix == 3'(e))) ? wdata_i[7:0] : 8'h00;
      release_bank[e] = con_wr && (con_ix == 3'(e)) && handover_ff[e] &&
                        wdata_i[uepcs_pkg::CON_HAND_CLR];
      launch[e] = (kind_ff[e] == uepcs_pkg::KIND_CTRL) &&
                  flag_ff[e][uepcs_pkg::ST_IN_READY] &&
                  clr_vec[e][uepcs_pkg::ST_IN_READY];
      ctl_free[e] = (kind_ff[e] == uepcs_pkg::KIND_CTRL) &&
                    ((flag_ff[e][uepcs_pkg::ST_OUT_RECV] &&
                      clr_vec[e][uepcs_pkg::ST_OUT_RECV]) ||
                     (flag_ff[e][uepcs_pkg::ST_SETUP] &&
                      clr_vec[e][uepcs_pkg::ST_SETUP]));
      grant[e] = reserve_ff[e] && !handover_ff[e] &&
                 (kind_ff[e] != uepcs_pkg::KIND_CTRL) &&
                 (dir_ff[e] ? (nbusy_ff[e] < eff_banks(banks_ff[e],
                                                       auto_ff[e]))
                            : (nbusy_ff[e] != 2'h0));
      if (grant[e]) begin
        if (dir_ff[e]) begin
          set_vec[e][uepcs_pkg::ST_IN_READY] = 1'b1;
        end else begin
          set_vec[e][uepcs_pkg::ST_OUT_RECV] = 1'b1;
        end
      end
      if (ev_sent[e] || (cfg_wr && (cfg_ix == 3'(e)) &&
          wdata_i[uepcs_pkg::CFG_RESERVE] &&
          (wdata_i[uepcs_pkg::CFG_KIND +: 2] == uepcs_pkg::KIND_CTRL))) begin
        set_vec[e][uepcs_pkg::ST_IN_READY] = 1'b1;
      end
    end
  end

  // bank ownership, busy count and current bank
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      handover_ff <= '0;
      loaded_ff <= '0;
      for (int e = 0; e < N; e++) begin
        nbusy_ff[e] <= 2'h0;
        curr_ff[e] <= 2'h0;
        toggle_ff[e] <= uepcs_pkg::TOGGLE_RST;
      end
    end else if (en_i) begin
      for (int e = 0; e < N; e++) begin
        if (grant[e]) begin
          handover_ff[e] <= 1'b1;
        end else if (release_bank[e]) begin
          handover_ff[e] <= 1'b0;
        end
        if (launch[e]) begin
          loaded_ff[e] <= 1'b1;
        end else if (ev_sent[e]) begin
          loaded_ff[e] <= 1'b0;
        end
        // in: software fills, host drains; out the other way round
        if (kind_ff[e] == uepcs_pkg::KIND_CTRL) begin
          if (ev_fill[e]) begin
            nbusy_ff[e] <= 2'h1;
          end else if (ctl_free[e]) begin
            nbusy_ff[e] <= 2'h0;
          end
        end else if (dir_ff[e]) begin
          nbusy_ff[e] <= nbusy_ff[e] + {1'b0, release_bank[e]}
                         - {1'b0, ev_take[e]};
        end else begin
          nbusy_ff[e] <= nbusy_ff[e] + {1'b0, ev_fill[e]}
                         - {1'b0, release_bank[e]};
        end
        if (release_bank[e]) begin
          curr_ff[e] <= (curr_ff[e] + 2'h1 >=
                         eff_banks(banks_ff[e], auto_ff[e]))
                        ? 2'h0 : curr_ff[e] + 2'h1;
        end
        if (ev_setup[e]) begin
          toggle_ff[e] <= 2'h0;
        end else if (ev_data[e]) begin
          toggle_ff[e] <= {1'b0, ~toggle_ff[e][0]};
        end
      end
    end
  end

  // sticky flags: a set in the clear cycle wins
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int e = 0; e < N; e++) begin
        flag_ff[e] <= 8'h00;
      end
    end else if (en_i) begin
      for (int e = 0; e < N; e++) begin
        flag_ff[e] <= (flag_ff[e] & ~clr_vec[e]) | set_vec[e];
      end
    end
  end

  // stall request and interrupt enables
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stall_ff <= '0;
      for (int e = 0; e < N; e++) begin
        irqen_ff[e] <= 8'h00;
      end
    end else if (en_i) begin
      for (int e = 0; e < N; e++) begin
        if (con_wr && (con_ix == 3'(e))) begin
          irqen_ff[e] <= wdata_i[uepcs_pkg::CON_IRQEN +: 8];
        end
        if (con_wr && (con_ix == 3'(e)) &&
            wdata_i[uepcs_pkg::CON_STALL_SET]) begin
          stall_ff[e] <= 1'b1;
        end else if (ev_setup[e] || (con_wr && (con_ix == 3'(e)) &&
                     wdata_i[uepcs_pkg::CON_STALL_CLR])) begin
          stall_ff[e] <= 1'b0;
        end
      end
    end
  end

  // visible flags: shared bit and direction masking
  function automatic logic [7:0] shown(input logic [7:0] f,
                                       input logic [1:0] k,
                                       input logic d);
    shown = f;
    if ((k == uepcs_pkg::KIND_BULK) || (k == uepcs_pkg::KIND_INTR)) begin
      shown[uepcs_pkg::ST_SETUP] = 1'b0;
    end
    if (k != uepcs_pkg::KIND_CTRL) begin
      shown[uepcs_pkg::ST_IN_READY] = f[uepcs_pkg::ST_IN_READY] & d;
      shown[uepcs_pkg::ST_OUT_RECV] = f[uepcs_pkg::ST_OUT_RECV] & ~d;
    end
    shown[7] = 1'b0;
  endfunction

  // read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff <= 32'h0;
    end else if (en_i) begin
      rdata_ff <= 32'h0;
      if (rd_i && hit(addr_i, uepcs_pkg::CFG_BASE)) begin
        rdata_ff[uepcs_pkg::CFG_RESERVE] <= reserve_ff[cfg_ix];
        rdata_ff[uepcs_pkg::CFG_BANKS +: 2] <= banks_ff[cfg_ix];
        rdata_ff[uepcs_pkg::CFG_SIZE +: 3] <= size_ff[cfg_ix];
        rdata_ff[uepcs_pkg::CFG_DIR] <= dir_ff[cfg_ix];
        rdata_ff[uepcs_pkg::CFG_AUTO] <= auto_ff[cfg_ix];
        rdata_ff[uepcs_pkg::CFG_KIND +: 2] <= kind_ff[cfg_ix];
      end else if (rd_i && hit(addr_i, uepcs_pkg::STA_BASE)) begin
        rdata_ff[7:0] <= shown(flag_ff[idx(addr_i, uepcs_pkg::STA_BASE)],
                               kind_ff[idx(addr_i, uepcs_pkg::STA_BASE)],
                               dir_ff[idx(addr_i, uepcs_pkg::STA_BASE)]);
        rdata_ff[uepcs_pkg::ST_TOGGLE +: 2] <=
          toggle_ff[idx(addr_i, uepcs_pkg::STA_BASE)];
        rdata_ff[uepcs_pkg::ST_NBUSY +: 2] <=
          nbusy_ff[idx(addr_i, uepcs_pkg::STA_BASE)];
        rdata_ff[uepcs_pkg::ST_CURR +: 2] <=
          curr_ff[idx(addr_i, uepcs_pkg::STA_BASE)];
        rdata_ff[uepcs_pkg::ST_CONFIG_VALID] <=
          config_valid_ff[idx(addr_i, uepcs_pkg::STA_BASE)];
      end else if (rd_i && hit(addr_i, uepcs_pkg::CON_BASE)) begin
        rdata_ff[uepcs_pkg::CON_STALL_SET] <= stall_ff[con_ix];
        rdata_ff[uepcs_pkg::CON_HANDOVER] <= handover_ff[con_ix];
        rdata_ff[uepcs_pkg::CON_IRQEN +: 8] <= irqen_ff[con_ix];
      end
    end
  end

  // handshake and interrupt outputs, registered
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hs_valid_ff <= 1'b0;
      hs_code_ff <= uepcs_pkg::HS_NONE;
      hs_ep_ff <= 3'h0;
      irq_ff <= 7'h00;
    end else if (en_i) begin
      hs_valid_ff <= (nxt_hs != uepcs_pkg::HS_NONE);
      hs_code_ff <= nxt_hs;
      hs_ep_ff <= tok_ep_i;
      for (int e = 0; e < N; e++) begin
        irq_ff[e] <= |(shown(flag_ff[e], kind_ff[e], dir_ff[e]) &
                       irqen_ff[e]);
      end
    end
  end

  assign rdata_o = rdata_ff;
  assign hs_valid_o = hs_valid_ff;
  assign hs_code_o = hs_code_ff;
  assign hs_ep_o = hs_ep_ff;
  assign endpoint_irq_o = irq_ff;

  a_reset_keeps_ep0:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      en_i && usb_reset_i |=> !reserve_ff[1] &&
      reserve_ff[0] == $past(reserve_ff[0]))
    else $error("bus reset handled endpoint allocation wrongly");
  a_reset_bank_fields:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      en_i && usb_reset_i |=> banks_ff[3] == 2'h0 && size_ff[3] == 3'h0
      && banks_ff[0] == $past(banks_ff[0]))
    else $error("bus reset left bank fields");
  a_reset_kind_dir:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      en_i && usb_reset_i |=> kind_ff[0] == 2'h0 && !dir_ff[2] && !auto_ff[2])
    else $error("bus reset left kind or direction");
  a_stall_answer:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      en_i && tok_valid_i && tok_ep_i == 3'h1 && reserve_ff[1] &&
      stall_ff[1] && tok_kind_i != uepcs_pkg::TOK_SETUP |=>
      hs_code_o == uepcs_pkg::HS_STALL && flag_ff[1][uepcs_pkg::ST_STALL])
    else $error("stall request not answered");
  a_iso_in_zlp:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      en_i && tok_valid_i && tok_ep_i == 3'h2 && reserve_ff[2] &&
      !stall_ff[2] && kind_ff[2] == uepcs_pkg::KIND_ISO && dir_ff[2] &&
      nbusy_ff[2] == 2'h0 && tok_kind_i == uepcs_pkg::TOK_IN |=>
      hs_code_o == uepcs_pkg::HS_ZLP && flag_ff[2][uepcs_pkg::ST_SETUP])
    else $error("iso underrun not reported");
  a_out_nak_flag:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      en_i && nxt_hs == uepcs_pkg::HS_NAK &&
      tok_kind_i == uepcs_pkg::TOK_OUT |=>
      flag_ff[$past(tok_ep_i)][uepcs_pkg::ST_OUT_REF])
    else $error("out refusal flag missing");
  a_oversize_ack:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      en_i && nxt_hs == uepcs_pkg::HS_ACK && tok_oversize_i &&
      tok_kind_i == uepcs_pkg::TOK_OUT |=>
      flag_ff[$past(tok_ep_i)][uepcs_pkg::ST_OVERS])
    else $error("oversize not flagged");
  a_clear_reads_zero:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      en_i && rd_i && hit(addr_i, uepcs_pkg::CLR_BASE) |=> rdata_o == 32'h0)
    else $error("status clear register read nonzero");
  a_cfg_bad_banks:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      en_i && !usb_reset_i && cfg_wr && wdata_i[uepcs_pkg::CFG_RESERVE] &&
      new_banks == uepcs_pkg::BANKS_RSVD |=> !config_valid_ff[$past(cfg_ix)])
    else $error("reserved bank count accepted");
  a_irq_from_flags:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      en_i && flag_ff[0] == 8'h00 ##1 en_i && flag_ff[0] == 8'h00
      |=> !endpoint_irq_o[0])
    else $error("interrupt without flag");
endmodule

// ===== dv/uepcs_usb_host.sv
// host model: issues one token and returns the answer
`timescale 1ns/1ps
module uepcs_usb_host (
  // clock
  input wire logic clk_i,
  // token to the device
  output logic tok_valid_o,
  output logic [2:0] tok_ep_o,
  output logic [1:0] tok_kind_o,
  output logic tok_oversize_o,
  // answer from the device
  input wire logic hs_valid_i,
  input wire uepcs_pkg::uepcs_hs_type hs_code_i,
  input wire logic [2:0] hs_ep_i
);
  initial begin
    tok_valid_o = 1'b0;
    tok_ep_o = 3'h0;
    tok_kind_o = 2'h0;
    tok_oversize_o = 1'b0;
  end
  // one-cycle token; the answer is looked at in the following cycle only
  task automatic send(input logic [2:0] e, input logic [1:0] k,
      input logic o, output uepcs_pkg::uepcs_hs_type c,
      output logic [2:0] p);
    tok_ep_o <= e;
    tok_kind_o <= k;
    tok_oversize_o <= o;
    tok_valid_o <= 1'b1;
    @(posedge clk_i);
    tok_valid_o <= 1'b0;
    tok_ep_o <= ~e; // idle endpoint lines do not keep the last value
    #1 c = hs_valid_i ? hs_code_i : uepcs_pkg::HS_NONE;
    p = hs_ep_i;
    @(posedge clk_i);
  endtask
endmodule

// ===== dv/testbench.sv
// register and token sequences with expected values
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [8:0] addr_i = 9'h000;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic usb_reset_i = 1'b0;
  logic en_i = 1'b1;
  logic [31:0] rdata_o;
  logic hs_valid_o, tok_valid, tok_ovs;
  logic [2:0] hs_ep_o, tok_ep, p;
  logic [1:0] tok_kind;
  logic [6:0] endpoint_irq_o;
  uepcs_pkg::uepcs_hs_type hs_code_o, c;
  int fail_count = 0;
  int checked = 0;
  always #50 clk_i = ~clk_i;
  uepcs_endpoint_ctrl DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .usb_reset_i(usb_reset_i), .tok_valid_i(tok_valid),
    .tok_ep_i(tok_ep), .tok_kind_i(tok_kind), .tok_oversize_i(tok_ovs),
    .hs_valid_o(hs_valid_o), .hs_code_o(hs_code_o), .hs_ep_o(hs_ep_o),
    .endpoint_irq_o(endpoint_irq_o));
  uepcs_usb_host HOST (.clk_i(clk_i), .tok_valid_o(tok_valid),
    .tok_ep_o(tok_ep), .tok_kind_o(tok_kind), .tok_oversize_o(tok_ovs),
    .hs_valid_i(hs_valid_o), .hs_code_i(hs_code_o), .hs_ep_i(hs_ep_o));
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    checked++;
    if (s !== e) begin
      $display("wrong value %s exp %h got %h", n, e, s);
      fail_count++;
    end
  endtask
  task automatic wr(logic [8:0] a, logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(string n, logic [8:0] a, logic [31:0] m, logic [31:0] e);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(n, e, rdata_o & m);
    @(posedge clk_i);
  endtask
  // one token, answer code and answering endpoint both checked
  task automatic tok(logic [2:0] e, logic [1:0] k, logic o,
                     uepcs_pkg::uepcs_hs_type x);
    HOST.send(e, k, o, c, p);
    chk("hs", 32'(x), 32'(c));
    chk("hs_ep", 32'(e), 32'(p));
  endtask
  task automatic report_and_stop;
    if (fail_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #3000000;
    fail_count++;
    report_and_stop;
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd("sta0", 9'h130, 32'hffffffff, 32'h100);
    rd("unmapped", 9'h000, 32'hffffffff, 32'h0);
    wr(9'h100, 32'h2);
    wr(9'h104, 32'h1002);
    rd("cfg1", 9'h104, 32'hffffffff, 32'h1002);
    rd("ok1", 9'h134, 32'h4007f, 32'h40000);
    tok(3'h1, uepcs_pkg::TOK_OUT, 1'b1, uepcs_pkg::HS_ACK);
    rd("sta1", 9'h134, 32'h7f, 32'h22);
    wr(9'h164, 32'h22);
    rd("clr1", 9'h134, 32'h7f, 32'h0);
    rd("clrreg", 9'h164, 32'hffffffff, 32'h0);
    wr(9'h1c4, 32'h4001);
    tok(3'h1, uepcs_pkg::TOK_OUT, 1'b0, uepcs_pkg::HS_STALL);
    rd("stall", 9'h134, 32'h40, 32'h40);
    #1 chk("irq", 32'h2, 32'(endpoint_irq_o));
    @(posedge clk_i);
    usb_reset_i <= 1'b1;
    @(posedge clk_i);
    usb_reset_i <= 1'b0;
    rd("rst1", 9'h104, 32'hffffffff, 32'h0);
    rd("rst0", 9'h100, 32'hffffffff, 32'h2);
    // control endpoint 0: IN refusal, launch, setup, OUT
    tok(3'h0, uepcs_pkg::TOK_IN, 1'b0, uepcs_pkg::HS_NAK);
    wr(9'h160, 32'h1);
    tok(3'h0, uepcs_pkg::TOK_IN, 1'b0, uepcs_pkg::HS_DATA);
    rd("sta0in", 9'h130, 32'h31f, 32'h11);
    tok(3'h0, uepcs_pkg::TOK_SETUP, 1'b0, uepcs_pkg::HS_ACK);
    tok(3'h0, uepcs_pkg::TOK_OUT, 1'b0, uepcs_pkg::HS_NAK);
    wr(9'h160, 32'h4);
    tok(3'h0, uepcs_pkg::TOK_OUT, 1'b0, uepcs_pkg::HS_ACK);
    rd("sta0out", 9'h130, 32'h300e, 32'h100a);
    // iso IN endpoint 2, two banks with auto switch
    wr(9'h108, 32'hb06);
    tok(3'h2, uepcs_pkg::TOK_IN, 1'b0, uepcs_pkg::HS_ZLP);
    rd("sta2", 9'h138, 32'h7, 32'h5);
    rd("hand2", 9'h1c8, 32'h8, 32'h8);
    wr(9'h168, 32'h1);
    wr(9'h1c8, 32'h4);
    rd("sta2b", 9'h138, 32'hf007, 32'h5005);
    tok(3'h2, uepcs_pkg::TOK_IN, 1'b0, uepcs_pkg::HS_DATA);
    // iso OUT endpoint 3, one bank: second packet dropped
    wr(9'h10c, 32'h802);
    tok(3'h3, uepcs_pkg::TOK_OUT, 1'b0, uepcs_pkg::HS_ACK);
    tok(3'h3, uepcs_pkg::TOK_OUT, 1'b0, uepcs_pkg::HS_DROP);
    // reserved bank count must not be accepted
    wr(9'h110, 32'he);
    rd("ok4", 9'h140, 32'h40000, 32'h0);
    // enable low: the write is lost
    en_i <= 1'b0;
    wr(9'h114, 32'h2);
    en_i <= 1'b1;
    rd("frozen", 9'h114, 32'hffffffff, 32'h0);
    report_and_stop;
  end
endmodule
